// ==== spi_slave_pkg.sv ====
// constants, phase codes and pin groups for the serial slave packet engine
`default_nettype none
package spi_slave_pkg;

	// -------------------------------------------------------------
	// packet framing
	// -------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int BIT_CNT_W = 4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BITS_OVER = 4'h9;
	localparam logic [3:0] BITS_NONE = 4'h0;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam int CTL_BROADCAST_BIT = 7;
	localparam int CTL_READ_BIT = 6;
	localparam int CTL_RESERVED_BIT = 5;
	localparam int CID_W = 5;
	localparam logic [3:0] CID_FIRST_CNT = 4'h3;
	localparam logic [3:0] CID_LAST_CNT = 4'h7;
	localparam logic [4:0] CID_TARGET = 5'h00;
	localparam logic [7:0] READ_EMPTY = 8'h00;

	// -------------------------------------------------------------
	// software register port
	// -------------------------------------------------------------
	localparam int SW_ADDR_W = 4;
	localparam int SW_DATA_W = 32;
	localparam logic [3:0] SW_CTRL_OFS = 4'h0;
	localparam logic [3:0] SW_STATUS_OFS = 4'h4;
	localparam logic [3:0] SW_LAST_OFS = 4'h8;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic CTRL_ENABLE_RESET = 1'b1;
	localparam logic [31:0] SW_READ_ZERO = 32'h0000_0000;
	localparam logic [7:0] COUNT_STEP = 8'h01;

	// -------------------------------------------------------------
	// packet phase, one-hot
	// -------------------------------------------------------------
	typedef enum logic [3:0]
	{
		PH_CONTROL = 4'b0001,
		PH_ADDRESS = 4'b0010,
		PH_DATA = 4'b0100,
		PH_LOST = 4'b1000
	} phase_e;

	// -------------------------------------------------------------
	// pin groups and register request
	// -------------------------------------------------------------
	typedef struct packed
	{
		logic sclk;
		logic select_n;
		logic serial_in;
	} spi_pins_in_s;

	typedef struct packed
	{
		logic serial_out;
		logic serial_out_oe;
		logic serial_in_forward;
	} spi_pins_out_s;

	typedef struct packed
	{
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

endpackage
`default_nettype wire

// ==== spi_slave_packet_engine.sv ====
// three-byte serial slave packet engine with daisy-chain forwarding
//
// Contract
// - packets are control byte, address byte, data byte, in that order
// - control bit 6 set means read, clear means write
// - broadcast flag has no effect on reads
// - write updates only the target, or every device when broadcast is set
// - forwarded chain position is decremented by one
// - second byte is the register address
// - third byte is write data in, or read data out
// - serial output driven only in the data byte of a read
// - bits are sampled on eight rising serial clock edges
// - select rising after eight bits advances the byte position
// - bit count other than zero or eight at select rise loses byte sync
// - serial clock rise with select high restarts the packet
// - after restart the next byte is a control byte
// - abandoned write leaves the register untouched
// - read of an unimplemented address returns zeros
// - chain position bits are reversed, lsb at control bit 4
// - device is target only when received position is zero
// - write to an unimplemented address updates nothing
// - all other bits pass to the forward output unchanged
`timescale 1ns/1ns
`default_nettype none
module spi_slave_packet_engine
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// serial pins
	input wire spi_slave_pkg::spi_pins_in_s pins_in,
	output spi_slave_pkg::spi_pins_out_s pins_out,
	// internal register file
	output spi_slave_pkg::reg_req_s reg_req_out,
	input wire logic [7:0] reg_rdata_in,
	input wire logic reg_hit_in,
	// software register port
	input wire logic [spi_slave_pkg::SW_ADDR_W-1:0] sw_addr_in,
	input wire logic [spi_slave_pkg::SW_DATA_W-1:0] sw_wdata_in,
	input wire logic sw_wr_in,
	input wire logic sw_rd_in,
	output logic [spi_slave_pkg::SW_DATA_W-1:0] sw_rdata_out
);
	import spi_slave_pkg::*;

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	// first stage read only by second stage
	spi_pins_in_s meta;
	spi_pins_in_s pins_s;
	logic sclk_d;
	logic sel_d;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_rise;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			meta <= '{sclk: 1'b0, select_n: 1'b1, serial_in: 1'b0};
			pins_s <= '{sclk: 1'b0, select_n: 1'b1, serial_in: 1'b0};
			sclk_d <= 1'b0;
			sel_d <= 1'b1;
		end
		else
		begin
			meta <= pins_in;
			pins_s <= meta;
			sclk_d <= pins_s.sclk;
			sel_d <= pins_s.select_n;
		end
	end

	assign sclk_rise = pins_s.sclk & ~sclk_d;
	assign sclk_fall = ~pins_s.sclk & sclk_d;
	assign sel_rise = pins_s.select_n & ~sel_d;

	// -------------------------------------------------------------
	// software control
	// -------------------------------------------------------------
	logic enable;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			enable <= CTRL_ENABLE_RESET;
		else if (sw_wr_in && sw_addr_in == SW_CTRL_OFS)
			enable <= sw_wdata_in[CTRL_ENABLE_BIT];
	end

	// -------------------------------------------------------------
	// packet phase and bit counting
	// -------------------------------------------------------------
	phase_e phase;
	logic [BIT_CNT_W-1:0] bit_cnt;
	logic [BYTE_W-1:0] rx_shift;
	logic [BYTE_W-1:0] ctl_byte;
	logic [BYTE_W-1:0] data_byte;
	logic byte_done;
	logic byte_bad;
	logic resync;
	logic shift_edge;
	logic is_read;
	logic is_target;
	logic [CID_W-1:0] chain_position_id;

	assign byte_done = sel_rise && bit_cnt == BITS_PER_BYTE;
	assign byte_bad = sel_rise && bit_cnt != BITS_PER_BYTE
		&& bit_cnt != BITS_NONE;
	assign resync = sclk_rise && pins_s.select_n;
	assign shift_edge = sclk_rise && !pins_s.select_n && phase != PH_LOST;

	// position lsb sits at control bit 4, msb at bit 0
	assign chain_position_id = {ctl_byte[0], ctl_byte[1], ctl_byte[2],
		ctl_byte[3], ctl_byte[4]};
	assign is_read = ctl_byte[CTL_READ_BIT];
	assign is_target = chain_position_id == CID_TARGET;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in || !enable)
			phase <= PH_CONTROL;
		else if (resync)
			phase <= PH_CONTROL;
		else if (byte_bad)
			phase <= PH_LOST;
		else if (byte_done)
		begin
			unique case (phase)
				PH_CONTROL: phase <= PH_ADDRESS;
				PH_ADDRESS: phase <= PH_DATA;
				PH_DATA: phase <= PH_CONTROL;
				PH_LOST: phase <= PH_LOST;
			endcase
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in || !enable || resync || sel_rise)
			bit_cnt <= BITS_NONE;
		else if (shift_edge && bit_cnt != BITS_OVER)
			bit_cnt <= bit_cnt + BIT_STEP;
	end

	// msb arrives first
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			rx_shift <= '0;
		else if (shift_edge)
			rx_shift <= {rx_shift[BYTE_W-2:0], pins_s.serial_in};
	end

	// reserved bit 5 is held but never decoded
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			ctl_byte <= '0;
		else if (byte_done && phase == PH_CONTROL)
			ctl_byte <= rx_shift;
	end

	// -------------------------------------------------------------
	// register file access
	// -------------------------------------------------------------
	logic load_pending;
	logic write_ok;
	logic req_write;
	logic [BYTE_W-1:0] req_addr;
	logic [BYTE_W-1:0] req_wdata;

	// address in its own process, write and data share one; the port struct is only a view
	assign reg_req_out = '{write: req_write, addr: req_addr,
		wdata: req_wdata};

	// broadcast only counts for writes
	assign write_ok = !is_read
		&& (ctl_byte[CTL_BROADCAST_BIT] || is_target);

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			req_addr <= '0;
		else if (byte_done && phase == PH_ADDRESS)
			req_addr <= rx_shift;
	end

	// write only on a clean eighth-bit close of the data byte
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			req_write <= 1'b0;
			req_wdata <= '0;
		end
		else
		begin
			req_write <= enable && byte_done && !resync
				&& phase == PH_DATA && write_ok
				&& reg_hit_in;
			if (byte_done && phase == PH_DATA)
				req_wdata <= rx_shift;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			load_pending <= 1'b0;
		else
			load_pending <= enable && byte_done && !resync
				&& phase == PH_ADDRESS;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			data_byte <= '0;
		else if (byte_done && phase == PH_DATA)
			data_byte <= rx_shift;
	end

	// -------------------------------------------------------------
	// read data return
	// -------------------------------------------------------------
	// address settles one cycle before the fetch; select high gap is far longer
	logic [BYTE_W-1:0] tx_shift;
	logic tx_bit;
	logic tx_enable;
	logic fwd_bit;

	assign pins_out = '{serial_out: tx_bit, serial_out_oe: tx_enable,
		serial_in_forward: fwd_bit};

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			tx_shift <= '0;
		else if (load_pending)
			tx_shift <= reg_hit_in ? reg_rdata_in : READ_EMPTY;
		else if (sclk_fall && phase == PH_DATA && !pins_s.select_n)
			tx_shift <= {tx_shift[BYTE_W-2:0], 1'b0};
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			tx_bit <= 1'b0;
			tx_enable <= 1'b0;
		end
		else
		begin
			tx_bit <= tx_shift[BYTE_W-1];
			tx_enable <= enable && phase == PH_DATA
				&& is_read && is_target
				&& !pins_s.select_n;
		end
	end

	// -------------------------------------------------------------
	// daisy-chain forwarding
	// -------------------------------------------------------------
	// serial decrement: borrow ripples from position lsb upward
	logic borrow;
	logic cid_window;

	assign cid_window = enable && phase == PH_CONTROL && !pins_s.select_n
		&& bit_cnt >= CID_FIRST_CNT && bit_cnt <= CID_LAST_CNT;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in || resync || sel_rise)
			borrow <= 1'b1;
		else if (shift_edge && cid_window)
			borrow <= borrow & ~pins_s.serial_in;
	end

	// registered path adds a few core cycles of delay to the chain
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			fwd_bit <= 1'b0;
		else
			fwd_bit <= pins_s.serial_in
				^ (cid_window & borrow);
	end

	// -------------------------------------------------------------
	// status counters
	// -------------------------------------------------------------
	logic [7:0] packet_count;
	logic [7:0] lost_count;
	logic [7:0] resync_count;

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			packet_count <= '0;
		else if (enable && byte_done && !resync && phase == PH_DATA)
			packet_count <= packet_count + COUNT_STEP;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			lost_count <= '0;
		else if (enable && byte_bad && !resync && phase != PH_LOST)
			lost_count <= lost_count + COUNT_STEP;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			resync_count <= '0;
		else if (enable && resync)
			resync_count <= resync_count + COUNT_STEP;
	end

	// -------------------------------------------------------------
	// software read port
	// -------------------------------------------------------------
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			sw_rdata_out <= SW_READ_ZERO;
		else if (!sw_rd_in)
			sw_rdata_out <= SW_READ_ZERO;
		else
		begin
			unique case (sw_addr_in)
				SW_CTRL_OFS:
					sw_rdata_out <= {31'h0000_0000, enable};
				SW_STATUS_OFS:
					sw_rdata_out <= {4'h0, phase, resync_count,
						lost_count, packet_count};
				SW_LAST_OFS:
					sw_rdata_out <= {8'h00, ctl_byte, req_addr,
						data_byte};
				default:
					sw_rdata_out <= SW_READ_ZERO;
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== spi_slave_packet_engine_checker.sv ====
// port assertions for the serial slave packet engine
`timescale 1ns/1ns
`default_nettype none
module spi_slave_packet_engine_checker
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// watched ports
	input wire spi_slave_pkg::spi_pins_in_s pins_in,
	input wire spi_slave_pkg::spi_pins_out_s pins_out,
	input wire spi_slave_pkg::reg_req_s reg_req_out,
	input wire logic reg_hit_in
);
	import spi_slave_pkg::*;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	// ---------------------------------------------
	// sequences
	// ---------------------------------------------
	sequence sel_idle;
		pins_in.select_n [*8];
	endsequence
	// six highs so the shift from the last fall has landed
	sequence clk_high;
		pins_in.sclk [*6];
	endsequence
	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	a_oe_idle_off: assert property (sel_idle |-> !pins_out.serial_out_oe)
		else $error("serial output driven while deselected");
	a_oe_drop: assert property ($rose(pins_in.select_n)
		|-> ##[1:8] !pins_out.serial_out_oe)
		else $error("serial output not released after select rise");
	a_oe_rise_sel: assert property ($rose(pins_out.serial_out_oe)
		|-> !pins_in.select_n)
		else $error("serial output enabled without select");
	a_write_pulse: assert property (reg_req_out.write
		|=> !reg_req_out.write)
		else $error("write pulse longer than one cycle");
	a_write_framed: assert property (reg_req_out.write
		|-> pins_in.select_n)
		else $error("write issued before byte close");
	a_write_no_oe: assert property (reg_req_out.write
		|-> !pins_out.serial_out_oe)
		else $error("serial output driven during write");
	a_write_hit: assert property (reg_req_out.write |-> reg_hit_in)
		else $error("write to unimplemented address");
	a_out_stable: assert property (clk_high ##0
		(pins_out.serial_out_oe && $past(pins_out.serial_out_oe))
		|-> $stable(pins_out.serial_out))
		else $error("read data changed while clock high");
endmodule
bind spi_slave_packet_engine spi_slave_packet_engine_checker chk_i
(
	.core_clk_in(core_clk_in),
	.rst_in(rst_in),
	.pins_in(pins_in),
	.pins_out(pins_out),
	.reg_req_out(reg_req_out),
	.reg_hit_in(reg_hit_in)
);
`default_nettype wire

// ==== spi_master_model.sv ====
// serial master model that frames bytes on the slave pins
`timescale 1ns/1ns
`default_nettype none
module spi_master_model
(
	// slave pins
	output spi_slave_pkg::spi_pins_in_s pins_out,
	input wire spi_slave_pkg::spi_pins_out_s pins_in
);
	import spi_slave_pkg::*;
	// clock low, select high, data low
	initial pins_out = 3'b010;
	// one byte framed by select; clock runs only inside the frame
	task automatic xfer(input logic [7:0] tx, input int n,
		output logic [7:0] rx, output logic [7:0] fw);
		rx = 'x;
		fw = 'x;
		pins_out.select_n <= 1'b0;
		#125;
		for (int i = 0; i < n; i++)
		begin
			pins_out.serial_in <= tx[3'(7 - i)];
			#62;
			pins_out.sclk <= 1'b1;
			#1;
			rx = {rx[6:0], pins_in.serial_out_oe ? pins_in.serial_out : 1'bx};
			fw = {fw[6:0], pins_in.serial_in_forward};
			#62;
			pins_out.sclk <= 1'b0;
		end
		#62;
		pins_out.select_n <= 1'b1;
		// released data line must not keep the last bit
		pins_out.serial_in <= ~pins_out.serial_in;
		#250;
	endtask
	// clock pulse with select high restarts the packet
	task automatic resync();
		pins_out.sclk <= 1'b1;
		#62;
		pins_out.sclk <= 1'b0;
		#125;
	endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the serial slave packet engine
`timescale 1ns/1ns
`default_nettype none
module tb;
	import spi_slave_pkg::*;
	typedef struct packed
	{
		logic [7:0] ctl;
		logic [7:0] addr;
		logic [7:0] data;
		logic [3:0] n;
		logic [7:0] rx;
		logic [1:0] idx;
		logic [7:0] val;
	} case_s;
	// ---------------------------------------------
	// signals and design
	// ---------------------------------------------
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	spi_pins_in_s pins_in;
	spi_pins_out_s pins_out;
	reg_req_s reg_req_out;
	logic [7:0] reg_rdata_in;
	logic reg_hit_in;
	logic [3:0] sw_addr_in = 4'h0;
	logic [31:0] sw_wdata_in = 32'h0000_0000;
	logic sw_wr_in = 1'b0;
	logic sw_rd_in = 1'b0;
	logic [31:0] sw_rdata_out;
	logic [7:0] regs [4];
	logic [31:0] d;
	logic [7:0] rx;
	logic [7:0] fw;
	int error_cnt = 0;
	int checks = 0;
	case_s cases [10] = '{
		'{8'h00, 8'h02, 8'h5A, 4'h8, 8'hxx, 2'h2, 8'h5A},
		'{8'h40, 8'h02, 8'h00, 4'h8, 8'h5A, 2'h2, 8'h5A},
		'{8'h10, 8'h01, 8'h33, 4'h8, 8'hxx, 2'h1, 8'h00},
		'{8'h90, 8'h01, 8'h77, 4'h8, 8'hxx, 2'h1, 8'h77},
		'{8'hC0, 8'h01, 8'h00, 4'h8, 8'h77, 2'h1, 8'h77},
		'{8'h50, 8'h01, 8'h00, 4'h8, 8'hxx, 2'h1, 8'h77},
		'{8'h40, 8'h80, 8'h00, 4'h8, 8'h00, 2'h1, 8'h77},
		'{8'h20, 8'h80, 8'h44, 4'h8, 8'hxx, 2'h0, 8'h00},
		'{8'h00, 8'h03, 8'h99, 4'h5, 8'hxx, 2'h3, 8'h00},
		'{8'h00, 8'h03, 8'h99, 4'h8, 8'hxx, 2'h3, 8'h99}
	};
	always #4 core_clk_in = ~core_clk_in;
	spi_master_model m (.pins_out(pins_in), .pins_in(pins_out));
	spi_slave_packet_engine dut
	(
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.pins_in(pins_in),
		.pins_out(pins_out),
		.reg_req_out(reg_req_out),
		.reg_rdata_in(reg_rdata_in),
		.reg_hit_in(reg_hit_in),
		.sw_addr_in(sw_addr_in),
		.sw_wdata_in(sw_wdata_in),
		.sw_wr_in(sw_wr_in),
		.sw_rd_in(sw_rd_in),
		.sw_rdata_out(sw_rdata_out)
	);
	// ---------------------------------------------
	// register file: ungated so a stray write shows
	// ---------------------------------------------
	assign reg_hit_in = reg_req_out.addr < 8'h04;
	assign reg_rdata_in = reg_hit_in ? regs[reg_req_out.addr[1:0]]
		: ~reg_req_out.addr;
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			regs <= '{default: 8'h00};
		else if (reg_req_out.write)
			regs[reg_req_out.addr[1:0]] <= reg_req_out.wdata;
	end
	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic sw_wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk_in);
		sw_addr_in <= a;
		sw_wdata_in <= v;
		sw_wr_in <= 1'b1;
		@(posedge core_clk_in);
		sw_wr_in <= 1'b0;
	endtask
	task automatic sw_rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge core_clk_in);
		sw_addr_in <= a;
		sw_rd_in <= 1'b1;
		@(posedge core_clk_in);
		sw_rd_in <= 1'b0;
		#1;
		v = sw_rdata_out;
	endtask
	task automatic pkt(input case_s c);
		logic [7:0] unused;
		m.xfer(c.ctl, 8, unused, fw);
		m.xfer(c.addr, 8, unused, unused);
		m.xfer(c.data, int'(c.n), rx, unused);
		if (c.n != 4'h8)
			m.resync();
		chk("read data", {24'h0, c.rx}, {24'h0, rx});
		chk("register", {24'h0, c.val}, {24'h0, regs[c.idx]});
	endtask
	// expected forward: chain position reversed, decremented
	function automatic logic [7:0] fwd(input logic [7:0] c);
		logic [4:0] id;
		id = {c[0], c[1], c[2], c[3], c[4]};
		id = id - 5'h01;
		return {c[7:5], id[0], id[1], id[2], id[3], id[4]};
	endfunction
	task automatic give_verdict();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ---------------------------------------------
	// sequence
	// ---------------------------------------------
	initial
	begin
		#200_000;
		error_cnt++;
		give_verdict();
	end
	initial
	begin
		repeat (16) @(posedge core_clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		sw_rd(SW_CTRL_OFS, d);
		chk("ctrl", 32'h0000_0001, d);
		sw_rd(4'hC, d);
		chk("unmapped", 32'h0000_0000, d);
		foreach (cases[i])
		begin
			pkt(cases[i]);
			chk("forward", {24'h0, fwd(cases[i].ctl)}, {24'h0, fw});
		end
		sw_rd(SW_LAST_OFS, d);
		chk("last", 32'h0000_0399, d);
		sw_wr(SW_CTRL_OFS, 32'h0000_0000);
		pkt('{8'h00, 8'h00, 8'hEE, 4'h8, 8'hxx, 2'h0, 8'h00});
		chk("raw forward", 32'h0000_0000, {24'h0, fw});
		sw_wr(SW_CTRL_OFS, 32'h0000_0001);
		sw_rd(SW_STATUS_OFS, d);
		chk("phase", 32'h0000_0001, {28'h0, d[27:24]});
		chk("status", 32'h0101_0109, d);
		give_verdict();
	end
endmodule
`default_nettype wire
